// file: sbpp_far_model.sv
// sbpp_far_model: external pin drivers and the host-side sample sink
// assumes: same clock as the port; stall is held by the bench
`timescale 1ns/1ns
module sbpp_far_model (
  input  wire logic       clk,      // system clock
  input  wire logic [7:0] pin_o,    // port output levels
  input  wire logic [7:0] pin_oe,   // port output enables
  input  wire logic [7:0] ext,      // external drive on input pins
  input  wire logic       stall,    // host fifo full
  input  wire logic       tx_valid, // sample push
  output logic      [7:0] pin_i,    // resolved pin levels
  output logic            tx_ready, // host fifo has room
  output int              pushes    // samples taken
);
  assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
  assign tx_ready = !stall;
  initial pushes = 0;
  always @(posedge clk) begin
    if (tx_valid && tx_ready) pushes <= pushes + 1;
  end
endmodule // sbpp_far_model

// file: sbpp_pin_drv.sv
// sbpp_pin_drv: per-pin output register and enable from direction mask
// assumes: load pulses come from the byte sequencer in the same domain
`timescale 1ns/1ns
module sbpp_pin_drv #(
  parameter int W = 8
) (
  input  wire logic         clk,      // system clock
  input  wire logic         rst_n,    // async reset, active low
  input  wire logic         load,     // apply new output byte
  input  wire logic [W-1:0] data,     // new output byte
  input  wire logic [W-1:0] dir_mask, // 1 = output
  output logic      [W-1:0] pin_o,    // pin output levels
  output logic      [W-1:0] pin_oe    // pin output enables
);
  logic [W-1:0] out_reg;

  // outputs change only on a load, hold between bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= sbpp_pkg::RST_OUT_DATA;
    end else if (load) begin
      out_reg <= data;
    end
  end

  assign pin_o  = out_reg;
  assign pin_oe = dir_mask;

endmodule // sbpp_pin_drv

// file: sbpp_pkg.sv
// sbpp_pkg: constants for the synchronous bit-bang parallel port
// assumes: single 250 MHz clock domain, no software registers
package sbpp_pkg;
  localparam int          DATA_W        = 8;
  localparam logic [7:0]  MODE_RESET    = 8'h00;
  localparam logic [7:0]  MODE_SYNC_BB  = 8'h04;
  localparam logic [7:0]  RST_MASK      = 8'h00;
  localparam logic [7:0]  RST_OUT_DATA  = 8'h00;
  localparam logic        RST_STROBE_N  = 1'b1;
  localparam int          SETUP_CYCLES  = 1;
  localparam logic [1:0]  SETUP_CNT_W1  = 2'h1;

  typedef enum logic [2:0] {
    SBPP_IDLE,
    SBPP_SAMPLE,
    SBPP_PUSH,
    SBPP_DRIVE,
    SBPP_SETUP,
    SBPP_WSTB,
    SBPP_WEND
  } sbpp_state_e;
endpackage

// file: sbpp_port.sv
// sbpp_port: synchronous bit-bang byte sequencer with pin and strobe drive
// assumes: host byte stream and return stream are valid/ready handshakes
// Notes on behaviour
// - outputs change only on a received byte
// - pulse write strobe after driving new byte
// - sample pins only per written byte
// - process byte only if return path ready
// - sample before drive; return lags one byte
// - mode code 04 enables this port
// - byte cycle begins by capturing all pins
// - read strobe high, queue sample to host
// - read strobe low, outputs switch new byte
// - one setup cycle before write strobe
// - write strobe returns high next step
// - read strobe rise marks sample captured
// - setup mask sets each pin direction
// - direction holds until next setup command
// - bytes still sampled; never drive input pins
// - mode code 00 resets mode logic
// - outputs hold last value between bytes
`timescale 1ns/1ns
module sbpp_port #(
  parameter int W = sbpp_pkg::DATA_W
) (
  input  wire logic         CLK_SYS,        // 250 MHz system clock
  input  wire logic         RST_N,          // async reset, active low
  input  wire logic         MODE_SET,       // mode-setup command strobe
  input  wire logic [7:0]   MODE_CODE,      // mode code with command
  input  wire logic [W-1:0] MODE_MASK,      // direction mask with command
  input  wire logic         RX_VALID,       // from_host_fifo byte present
  input  wire logic [W-1:0] RX_DATA,        // from_host_fifo byte
  output logic              RX_READY,       // pop from_host_fifo
  output logic              TX_VALID,       // to_host_fifo push
  output logic      [W-1:0] TX_DATA,        // sampled pin byte
  input  wire logic         TX_READY,       // to_host_fifo has room
  input  wire logic [W-1:0] PIN_I,          // pin input levels
  output logic      [W-1:0] PIN_O,          // pin output levels
  output logic      [W-1:0] PIN_OE,         // pin output enables
  output logic              WRITE_STROBE_N, // write strobe, active low
  output logic              READ_STROBE_N,  // read strobe, active low
  output logic              MODE_ACTIVE     // sync bit-bang enabled
);
  sbpp_pkg::sbpp_state_e state;
  sbpp_pkg::sbpp_state_e next_state;
  logic         enabled;
  logic [W-1:0] dir_mask;
  logic [W-1:0] held_byte;
  logic [1:0]   setup_cnt;
  logic         load;

  function automatic logic is_code(input logic [7:0] c,
                                   input logic [7:0] ref_c);
    return c == ref_c;
  endfunction

  // mode enable and reset
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      enabled <= 1'b0;
    end else if (MODE_SET) begin
      if (is_code(MODE_CODE, sbpp_pkg::MODE_SYNC_BB)) begin
        enabled <= 1'b1;
      end else begin
        enabled <= 1'b0;
      end
    end
  end

  // direction mask, only a setup command changes it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      dir_mask <= sbpp_pkg::RST_MASK;
    end else if (MODE_SET) begin
      if (is_code(MODE_CODE, sbpp_pkg::MODE_RESET)) begin
        dir_mask <= sbpp_pkg::RST_MASK;
      end else begin
        dir_mask <= MODE_MASK;
      end
    end
  end

  // start a byte only with room in to_host_fifo
  assign RX_READY = (state == sbpp_pkg::SBPP_IDLE) && enabled
                    && !MODE_SET && TX_READY;

  always_comb begin
    next_state = state;
    case (state)
      sbpp_pkg::SBPP_IDLE: begin
        if (RX_READY && RX_VALID) begin
          next_state = sbpp_pkg::SBPP_SAMPLE;
        end
      end
      sbpp_pkg::SBPP_SAMPLE: begin
        next_state = sbpp_pkg::SBPP_PUSH;
      end
      sbpp_pkg::SBPP_PUSH: begin
        if (TX_READY) begin
          next_state = sbpp_pkg::SBPP_DRIVE;
        end
      end
      sbpp_pkg::SBPP_DRIVE: begin
        next_state = sbpp_pkg::SBPP_SETUP;
      end
      sbpp_pkg::SBPP_SETUP: begin
        if (setup_cnt + 2'h1 == sbpp_pkg::SETUP_CNT_W1) begin
          next_state = sbpp_pkg::SBPP_WSTB;
        end
      end
      sbpp_pkg::SBPP_WSTB: begin
        next_state = sbpp_pkg::SBPP_WEND;
      end
      sbpp_pkg::SBPP_WEND: begin
        next_state = sbpp_pkg::SBPP_IDLE;
      end
      default: begin
        next_state = sbpp_pkg::SBPP_IDLE;
      end
    endcase
  end

  // a reset-mode command aborts the byte cycle
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state <= sbpp_pkg::SBPP_IDLE;
    end else if (MODE_SET && !is_code(MODE_CODE, sbpp_pkg::MODE_SYNC_BB))
    begin
      state <= sbpp_pkg::SBPP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // setup delay counter
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      setup_cnt <= 2'h0;
    end else if (state == sbpp_pkg::SBPP_SETUP) begin
      setup_cnt <= setup_cnt + 2'h1;
    end else begin
      setup_cnt <= 2'h0;
    end
  end

  // capture host byte on pop, pins at the first step
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      held_byte <= sbpp_pkg::RST_OUT_DATA;
    end else if (RX_READY && RX_VALID) begin
      held_byte <= RX_DATA;
    end
  end

  // return byte to host
  assign TX_VALID = (state == sbpp_pkg::SBPP_PUSH);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TX_DATA <= sbpp_pkg::RST_OUT_DATA;
    end else if (state == sbpp_pkg::SBPP_SAMPLE) begin
      TX_DATA <= PIN_I;
    end
  end

  // read strobe: high during push, low otherwise
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      READ_STROBE_N <= sbpp_pkg::RST_STROBE_N;
    end else if (next_state == sbpp_pkg::SBPP_PUSH) begin
      READ_STROBE_N <= 1'b1;
    end else begin
      READ_STROBE_N <= 1'b0;
    end
  end

  // write strobe one cycle wide
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      WRITE_STROBE_N <= sbpp_pkg::RST_STROBE_N;
    end else begin
      WRITE_STROBE_N <= !(next_state == sbpp_pkg::SBPP_WSTB);
    end
  end

  assign load        = (state == sbpp_pkg::SBPP_DRIVE);
  assign MODE_ACTIVE = enabled;

  sbpp_pin_drv #(
    .W(W)
  ) u_pins (
    .clk      (CLK_SYS),
    .rst_n    (RST_N),
    .load     (load),
    .data     (held_byte),
    .dir_mask (dir_mask),
    .pin_o    (PIN_O),
    .pin_oe   (PIN_OE)
  );

  AST_NO_SPONT_TX: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TX_VALID |-> $past(state == sbpp_pkg::SBPP_SAMPLE) ||
      $past(state == sbpp_pkg::SBPP_PUSH))
    else $error("tx push without a byte cycle");

  AST_OUT_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !$past(load) |-> $stable(PIN_O))
    else $error("pin outputs changed without a byte");

  AST_POP_ROOM: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    RX_READY |-> TX_READY && enabled)
    else $error("byte popped without return room");

  AST_SAMPLE_PINS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    state == sbpp_pkg::SBPP_SAMPLE |=> TX_DATA == $past(PIN_I))
    else $error("sample not taken from pins");

  AST_RD_HIGH: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    TX_VALID |-> READ_STROBE_N)
    else $error("read strobe low while queuing sample");

  AST_DRIVE_NEW: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    load |=> PIN_O == $past(held_byte) && !READ_STROBE_N)
    else $error("new byte not driven with read strobe low");

  AST_SETUP_GAP: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(load) |=> WRITE_STROBE_N ##1 !WRITE_STROBE_N)
    else $error("write strobe timing wrong after drive");

  AST_WR_PULSE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $fell(WRITE_STROBE_N) |=> WRITE_STROBE_N)
    else $error("write strobe wider than one cycle");

  AST_RD_RISE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(READ_STROBE_N) && !$past(state == sbpp_pkg::SBPP_IDLE)
      |-> TX_DATA == $past(PIN_I))
    else $error("read strobe rose without captured sample");

  AST_DIR_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !$past(MODE_SET) |-> $stable(PIN_OE))
    else $error("direction changed without setup");

  AST_MODE_RESET: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    MODE_SET && MODE_CODE == sbpp_pkg::MODE_RESET |=>
      !MODE_ACTIVE && state == sbpp_pkg::SBPP_IDLE)
    else $error("reset code did not leave bit-bang");

  AST_MODE_ON: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    MODE_SET && MODE_CODE == sbpp_pkg::MODE_SYNC_BB |=>
      MODE_ACTIVE && PIN_OE == $past(MODE_MASK))
    else $error("mode 04 did not enable port");

  AST_WR_AFTER_LOAD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $fell(WRITE_STROBE_N) |->
      $past(load, 2))
    else $error("write strobe without a driven byte");

  AST_WR_IN_WSTB: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    state == sbpp_pkg::SBPP_WSTB |->
      !WRITE_STROBE_N)
    else $error("write strobe high in strobe step");

  AST_TX_HOLD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    TX_VALID && !TX_READY |=>
      $stable(TX_DATA))
    else $error("sample changed while waiting for room");

  AST_PUSH_WAIT: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    TX_VALID && !TX_READY && !MODE_SET |=>
      TX_VALID)
    else $error("sample push dropped while host fifo full");

  AST_SAMPLE_THEN_PUSH: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    state == sbpp_pkg::SBPP_SAMPLE && !MODE_SET |=>
      TX_VALID)
    else $error("captured sample not queued");

  AST_LOAD_AFTER_PUSH: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    load |->
      $past(TX_VALID && TX_READY))
    else $error("outputs driven before sample queued");

  AST_WR_DATA_STABLE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !WRITE_STROBE_N |->
      $stable(PIN_O))
    else $error("pin outputs moved during write strobe");

  AST_MASK_LOAD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    MODE_SET && MODE_CODE != sbpp_pkg::MODE_RESET |=>
      PIN_OE == $past(MODE_MASK))
    else $error("direction mask not applied");

  AST_DIR_CLEAR: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    MODE_SET && MODE_CODE == sbpp_pkg::MODE_RESET |=>
      PIN_OE == sbpp_pkg::RST_MASK)
    else $error("reset code left pins driven");

  AST_OFF_NO_POP: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !MODE_ACTIVE |->
      !RX_READY)
    else $error("byte popped while port disabled");

  AST_MODE_HOLD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !$past(MODE_SET) |->
      $stable(MODE_ACTIVE))
    else $error("mode changed without a command");

  AST_TX_ONLY_SAMPLE: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    $changed(TX_DATA) |->
      $past(state == sbpp_pkg::SBPP_SAMPLE))
    else $error("return byte changed outside sample step");

  AST_OE_KEEP_ON_LOAD: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    load && !MODE_SET |=>
      $stable(PIN_OE))
    else $error("byte load changed pin directions");

  AST_RD_LOW_SETUP: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    state == sbpp_pkg::SBPP_SETUP |->
      !READ_STROBE_N)
    else $error("read strobe high during setup");

  AST_POP_STARTS: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RX_READY && RX_VALID |=>
      state == sbpp_pkg::SBPP_SAMPLE)
    else $error("byte cycle did not start with a sample");

  AST_CYCLE_END: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    state == sbpp_pkg::SBPP_WSTB && !MODE_SET |=>
      WRITE_STROBE_N && state == sbpp_pkg::SBPP_WEND)
    else $error("write strobe did not end the cycle");

  AST_HELD_ON_POP: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    RX_READY && RX_VALID |=>
      held_byte == $past(RX_DATA))
    else $error("popped byte not held for output");

endmodule // sbpp_port

// file: tb.sv
// tb: self-checking bench for the bit-bang byte sequencer
// assumes: far side modelled by sbpp_far_model
`timescale 1ns/1ns
module tb;
  logic        clk, rst_n, mode_set, rx_valid, stall;
  logic [7:0]  mode_code, mode_mask, rx_data, ext, m, x, d, s, o;
  logic        rx_ready, tx_valid, tx_ready, wstb_n, rstb_n, active;
  logic [7:0]  tx_data, pin_i, pin_o, pin_oe;
  int          num_errors, samples_checked, pushes, n, p0;
  // mask, external drive, byte sent, expected sample
  logic [31:0] rows [7] = '{32'hFF00FF00, 32'hFF0055FF, 32'hFF00AA55,
    32'hFF00AAAA, 32'h0F5A3C5A, 32'h0F5A005C, 32'h00C377C3};

  sbpp_port u_sbpp_port (.CLK_SYS(clk), .RST_N(rst_n),
    .MODE_SET(mode_set), .MODE_CODE(mode_code), .MODE_MASK(mode_mask),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .RX_READY(rx_ready),
    .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_READY(tx_ready),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe),
    .WRITE_STROBE_N(wstb_n), .READ_STROBE_N(rstb_n),
    .MODE_ACTIVE(active));
  sbpp_far_model u_sbpp_far_model (.clk(clk), .pin_o(pin_o),
    .pin_oe(pin_oe), .ext(ext), .stall(stall), .tx_valid(tx_valid),
    .pin_i(pin_i), .tx_ready(tx_ready), .pushes(pushes));

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic mode(logic [7:0] c, logic [7:0] k, logic [7:0] e);
    @(posedge clk);
    mode_set <= 1'b1;
    mode_code <= c;
    mode_mask <= k;
    ext <= e;
    @(posedge clk);
    mode_set <= 1'b0;
    @(negedge clk);
    chk("active", {7'h00, c == 8'h04}, {7'h00, active});
    chk("dir", (c == 8'h00) ? 8'h00 : k, pin_oe);
  endtask

  task automatic send(logic [7:0] b, logic [7:0] smp, logic [7:0] p);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge clk);
    for (n = 0; rx_ready !== 1'b1 && n < 50; n++) @(negedge clk);
    @(posedge clk);
    rx_valid <= 1'b0;
    p0 = pushes;
    for (n = 1; n <= 5; n++) begin
      @(negedge clk);
      if (n == 2) begin
        chk("sample", smp, tx_data);
        chk("rd_hi", 8'h01, {7'h00, rstb_n});
        chk("push", 8'h01, {7'h00, tx_valid});
      end
      if (n == 3) chk("rd_lo", 8'h00, {7'h00, rstb_n});
      if (n == 4) chk("wr_wait", 8'h01, {7'h00, wstb_n});
    end
    chk("wr_lo", 8'h00, {7'h00, wstb_n});
    chk("pins", p, pin_i);
    @(negedge clk);
    chk("wr_hi", 8'h01, {7'h00, wstb_n});
    chk("pushes", 8'(p0 + 1), 8'(pushes));
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end

  initial begin
    {rst_n, mode_set, rx_valid, stall} = 4'h0;
    {mode_code, mode_mask, rx_data, ext} = 32'h0;
    num_errors = 0;
    samples_checked = 0;
    repeat (9) @(posedge clk);
    @(negedge clk);
    chk("rst_strobes", 8'h03, {6'h00, wstb_n, rstb_n});
    chk("rst_oe", 8'h00, pin_oe);
    chk("rst_act", 8'h00, {7'h00, active});
    @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      {m, x, d, s} = rows[i];
      if (i == 0 || m !== mode_mask) mode(8'h04, m, x);
      send(d, s, (d & m) | (x & ~m));
    end
    // idle: nothing moves without a byte
    p0 = pushes;
    o = pin_i;
    repeat (20) @(negedge clk);
    chk("idle_pins", o, pin_i);
    chk("idle_push", 8'(p0), 8'(pushes));
    // host fifo full holds the byte back
    @(posedge clk);
    stall <= 1'b1;
    rx_valid <= 1'b1;
    rx_data <= 8'h12;
    repeat (20) @(negedge clk);
    chk("stall_pop", 8'h00, {7'h00, rx_ready});
    chk("stall_push", 8'(p0), 8'(pushes));
    @(posedge clk);
    stall <= 1'b0;
    rx_valid <= 1'b0;
    send(8'h12, 8'hC3, 8'hC3);
    mode(8'h01, 8'h0F, 8'h00);
    mode(8'h00, 8'hFF, 8'h00);
    @(posedge clk);
    rx_valid <= 1'b1;
    repeat (10) @(negedge clk);
    chk("off_pop", 8'h00, {7'h00, rx_ready});
    close_out();
  end
endmodule // tb
